//--- hw/vsch_pkg.sv
/*
 * Shared constants, types and register map of the verify and security command handler.
 * Assumes a single 20 MHz clock, an AHB-Lite master in front and one media checker behind.
 */
// Functional notes
// - verify moves no data, never data request
// - busy while verifying, interrupt at end
// - 28-bit failure leaves failing sector address
// - on failure count shows unverified sectors
// - 48-bit registers: high byte first, low second
// - 48-bit success leaves last verified address
// - 48-bit failure leaves failing block address
// - opcode 1Xh completes doing nothing
// - disable password: matching payload clears lock
// - disable password keeps master password intact
// - payload: word0 id bit, words 1-16 password
// - erase unit aborted without prior prepare
// - erase unit password mismatch aborts command
// - freeze lock rejects lock changing commands
// - frozen cleared only by hardware reset
// - freeze while frozen completes, stays frozen
// - no security support: freeze means wear level
package vsch_pkg;

    localparam int CLK_HZ = 20000000;

    // byte offsets on the register bus
    localparam logic [7:0] OFF_DATA   = 8'h00;
    localparam logic [7:0] OFF_FEAT   = 8'h04;
    localparam logic [7:0] OFF_SCNT   = 8'h08;
    localparam logic [7:0] OFF_LBALO  = 8'h0C;
    localparam logic [7:0] OFF_LBAMID = 8'h10;
    localparam logic [7:0] OFF_LBAHI  = 8'h14;
    localparam logic [7:0] OFF_DRVHD  = 8'h18;
    localparam logic [7:0] OFF_CMD    = 8'h1C;
    localparam logic [7:0] OFF_DEVCTL = 8'h20;
    localparam logic [7:0] OFF_SECCFG = 8'h24;
    localparam logic [7:0] OFF_PWLOAD = 8'h28;

    // opcodes
    localparam logic [7:0] CMD_VFY_A   = 8'h40;
    localparam logic [7:0] CMD_VFY_B   = 8'h41;
    localparam logic [7:0] CMD_VFY_EXT = 8'h42;
    localparam logic [3:0] CMD_RECAL_N = 4'h1;
    localparam logic [7:0] CMD_ERPREP  = 8'hF3;
    localparam logic [7:0] CMD_ERUNIT  = 8'hF4;
    localparam logic [7:0] CMD_FREEZE  = 8'hF5;
    localparam logic [7:0] CMD_DISPW   = 8'hF6;

    // field positions
    localparam int HOB_BIT    = 7;
    localparam int DH_LBA_BIT = 6;
    localparam int PWL_IDX_LO = 16;
    localparam int PWL_MASTER = 20;
    localparam int SC_SUP_BIT = 4;

    // payload layout
    localparam logic [8:0] PAY_LAST = 9'h0FF;
    localparam logic [8:0] PW_LAST  = 9'h010;

    localparam logic [16:0] CNT28_ZERO = 17'h00100;
    localparam logic [16:0] CNT48_ZERO = 17'h10000;

    localparam logic [7:0] DH_RESET  = 8'hA0;
    localparam logic       SUP_RESET = 1'b1;

    typedef enum logic [2:0] {S_IDLE, S_REQ, S_WAIT, S_PAY} vsch_state_t;

    typedef struct packed {
        logic busy;
        logic data_request_flag;
        logic unc;
        logic abrt;
    } vsch_stat_t;

    // current and previous byte of a 16-bit task-file register
    typedef struct packed {
        logic [7:0] prev;
        logic [7:0] cur;
    } vsch_pair_t;

endpackage

//--- hw/vsch_pw_store.sv
/*
 * Password store and payload comparator.
 * Assumes payload words arrive one per pay_en after a start pulse, 256 words per sector.
 */
module vsch_pw_store
    import vsch_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ld_en,
    input  wire logic        ld_master,
    input  wire logic [3:0]  ld_idx,
    input  wire logic [15:0] ld_word,
    input  wire logic        clr_user,
    input  wire logic        start,
    input  wire logic        pay_en,
    input  wire logic [15:0] pay_word,
    output logic             done,
    output logic             match,
    output logic             user_set
);

    logic [15:0] pw_mem [0:1][0:15];
    logic [8:0]  cnt_r;
    logic        id_r;
    logic        ok_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 2; i++) begin
                for (int j = 0; j < 16; j++) begin
                    pw_mem[i][j] <= 16'h0000;
                end
            end
        end else if (ld_en) begin
            pw_mem[ld_master][ld_idx] <= ld_word;
        end
    end

    // word 0 picks the password, words 1-16 compared, the rest ignored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 9'h000;
            id_r  <= 1'b0;
            ok_r  <= 1'b1;
        end else if (start) begin
            cnt_r <= 9'h000;
            ok_r  <= 1'b1;
        end else if (pay_en) begin
            cnt_r <= cnt_r + 9'h001;
            if (cnt_r == 9'h000) begin
                id_r <= pay_word[0];
            end else if (cnt_r <= PW_LAST && pay_word != pw_mem[id_r][4'(cnt_r - 9'h001)]) begin
                ok_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done  <= 1'b0;
            match <= 1'b0;
        end else begin
            done  <= pay_en && cnt_r == PAY_LAST;
            match <= ok_r;
        end
    end

    // only the user flag drops; master words stay stored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            user_set <= 1'b0;
        end else if (ld_en && !ld_master) begin
            user_set <= 1'b1;
        end else if (clr_user) begin
            user_set <= 1'b0;
        end
    end

endmodule

//--- hw/vsch_top.sv
/*
 * Task-file command handler: read verify, recalibrate and the security commands.
 * Assumes a zero-wait AHB-Lite slave position and an external media checker
 * that answers each chk_req pulse with one chk_done pulse.
 */
module vsch_top
    import vsch_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             chk_req,
    output logic      [47:0] chk_lba,
    input  wire logic        chk_done,
    input  wire logic        chk_err,
    output logic             intrq,
    output logic             erase_unit,
    output logic             wear_level
);

    vsch_state_t state_r;
    vsch_state_t state_nxt;
    vsch_stat_t  st_r;

    logic [7:0]  addr_r;
    logic        wr_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;

    vsch_pair_t  cnt_r;
    vsch_pair_t  lo_r;
    vsch_pair_t  mid_r;
    vsch_pair_t  hi_r;
    logic [7:0]  feat_r;
    logic [7:0]  dh_r;
    logic        hob_r;
    logic        sup_r;
    logic        frozen_r;
    logic        locked_r;
    logic        prepare_r;
    logic        ext_r;
    logic        erase_op_r;
    logic [16:0] rem_r;
    logic [47:0] lba_r;
    logic        chk_req_r;
    logic        intrq_r;
    logic        erase_r;
    logic        wear_r;

    logic        cmd_go;
    logic        fin;
    logic        fin_abrt;
    logic        fin_unc;
    logic        vfy_start;
    logic        pay_start;
    logic        pw_done;
    logic        pw_match;
    logic        user_set;
    logic        stat_rd;
    logic        vfy_end;
    logic        clr_user;
    logic [7:0]  opc;

    function automatic logic [7:0] pick(input vsch_pair_t p, input logic high_order_byte_select);
        return high_order_byte_select ? p.prev : p.cur;
    endfunction

    // a write shifts the old low byte into the high byte
    function automatic vsch_pair_t push(input vsch_pair_t p, input logic [7:0] b);
        return '{prev: p.cur, cur: b};
    endfunction

    assign hrdata     = hrdata_r;
    assign hreadyout  = hreadyout_r;
    assign hresp      = 1'b0;
    assign chk_req    = chk_req_r;
    assign chk_lba    = lba_r;
    assign intrq      = intrq_r;
    assign erase_unit = erase_r;
    assign wear_level = wear_r;

    assign opc     = hwdata[7:0];
    assign cmd_go  = wr_r && addr_r == OFF_CMD && state_r == S_IDLE;
    assign stat_rd = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == OFF_CMD;
    assign vfy_end = state_r == S_WAIT && chk_done && (chk_err || rem_r == 17'h00001);

    // bus front end: zero wait, read data fetched in the address phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_r      <= 8'h00;
            wr_r        <= 1'b0;
            hreadyout_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            wr_r        <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // a read straight after a write to the same word still sees the old value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                OFF_FEAT:   hrdata_r <= {24'h000000, 1'b0, st_r.unc, 3'h0, st_r.abrt, 2'h0};
                OFF_SCNT:   hrdata_r <= {24'h000000, pick(cnt_r, hob_r)};
                OFF_LBALO:  hrdata_r <= {24'h000000, pick(lo_r, hob_r)};
                OFF_LBAMID: hrdata_r <= {24'h000000, pick(mid_r, hob_r)};
                OFF_LBAHI:  hrdata_r <= {24'h000000, pick(hi_r, hob_r)};
                OFF_DRVHD:  hrdata_r <= {24'h000000, dh_r};
                OFF_CMD:    hrdata_r <= {24'h000000, st_r.busy, ~st_r.busy, 2'h0, st_r.data_request_flag,
                                         2'h0, st_r.unc | st_r.abrt};
                OFF_DEVCTL: hrdata_r <= {24'h000000, hob_r, 7'h00};
                OFF_SECCFG: hrdata_r <= {27'h0000000, sup_r, locked_r, frozen_r, prepare_r,
                                         user_set};
                default:    hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // command decode and sequencing
    always_comb begin
        state_nxt = state_r;
        fin       = 1'b0;
        fin_abrt  = 1'b0;
        fin_unc   = 1'b0;
        vfy_start = 1'b0;
        pay_start = 1'b0;
        unique case (state_r)
            S_IDLE: begin
                if (cmd_go) begin
                    if (opc == CMD_VFY_A || opc == CMD_VFY_B || opc == CMD_VFY_EXT) begin
                        vfy_start = 1'b1;
                        state_nxt = S_REQ;
                    end else if (opc[7:4] == CMD_RECAL_N) begin
                        fin = 1'b1;
                    end else if (opc == CMD_ERPREP || opc == CMD_FREEZE) begin
                        fin = 1'b1;
                    end else if (opc == CMD_ERUNIT) begin
                        if (frozen_r || !prepare_r) begin
                            fin      = 1'b1;
                            fin_abrt = 1'b1;
                        end else begin
                            pay_start = 1'b1;
                            state_nxt = S_PAY;
                        end
                    end else if (opc == CMD_DISPW) begin
                        if (frozen_r) begin
                            fin      = 1'b1;
                            fin_abrt = 1'b1;
                        end else begin
                            pay_start = 1'b1;
                            state_nxt = S_PAY;
                        end
                    end else begin
                        fin      = 1'b1;
                        fin_abrt = 1'b1;
                    end
                end
            end
            S_REQ: begin
                state_nxt = S_WAIT;
            end
            S_WAIT: begin
                if (chk_done) begin
                    if (chk_err) begin
                        fin       = 1'b1;
                        fin_unc   = 1'b1;
                        state_nxt = S_IDLE;
                    end else if (rem_r == 17'h00001) begin
                        fin       = 1'b1;
                        state_nxt = S_IDLE;
                    end else begin
                        state_nxt = S_REQ;
                    end
                end
            end
            S_PAY: begin
                if (pw_done) begin
                    fin       = 1'b1;
                    fin_abrt  = !pw_match;
                    state_nxt = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r   <= S_IDLE;
            chk_req_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            chk_req_r <= state_nxt == S_REQ;
        end
    end

    // verify walker: remaining count and current block
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_r <= 1'b0;
            rem_r <= 17'h00000;
            lba_r <= 48'h0000_0000_0000;
        end else if (vfy_start) begin
            ext_r <= opc == CMD_VFY_EXT;
            if (opc == CMD_VFY_EXT) begin
                rem_r <= (cnt_r == 16'h0000) ? CNT48_ZERO : {1'b0, cnt_r};
                lba_r <= {hi_r.prev, mid_r.prev, lo_r.prev, hi_r.cur, mid_r.cur, lo_r.cur};
            end else begin
                rem_r <= (cnt_r.cur == 8'h00) ? CNT28_ZERO : {9'h000, cnt_r.cur};
                lba_r <= {20'h00000, dh_r[3:0], hi_r.cur, mid_r.cur, lo_r.cur};
            end
        end else if (state_r == S_WAIT && chk_done && !chk_err && rem_r != 17'h00001) begin
            rem_r <= rem_r - 17'h00001;
            lba_r <= lba_r + 48'h0000_0000_0001;
        end
    end

    // task-file registers: host writes when idle (device control in any state), write-back at verify end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r  <= '0;
            lo_r   <= '0;
            mid_r  <= '0;
            hi_r   <= '0;
            feat_r <= 8'h00;
            dh_r   <= DH_RESET;
            hob_r  <= 1'b0;
        end else if (vfy_end) begin
            // failing or last verified block stays visible
            if (ext_r) begin
                hi_r  <= '{prev: lba_r[47:40], cur: lba_r[23:16]};
                mid_r <= '{prev: lba_r[39:32], cur: lba_r[15:8]};
                lo_r  <= '{prev: lba_r[31:24], cur: lba_r[7:0]};
            end else begin
                dh_r  <= {dh_r[7:4], lba_r[27:24]};
                hi_r  <= '{prev: hi_r.prev, cur: lba_r[23:16]};
                mid_r <= '{prev: mid_r.prev, cur: lba_r[15:8]};
                lo_r  <= '{prev: lo_r.prev, cur: lba_r[7:0]};
            end
            if (chk_err) begin
                // failing sector counts as not yet verified
                cnt_r <= ext_r ? rem_r[15:0] : '{prev: cnt_r.prev, cur: rem_r[7:0]};
            end
        end else if (wr_r) begin
            if (addr_r == OFF_DEVCTL) begin
                hob_r <= hwdata[HOB_BIT];
            end
            if (state_r == S_IDLE) begin
                unique case (addr_r)
                    OFF_FEAT:   feat_r <= hwdata[7:0];
                    OFF_SCNT:   cnt_r  <= push(cnt_r, hwdata[7:0]);
                    OFF_LBALO:  lo_r   <= push(lo_r, hwdata[7:0]);
                    OFF_LBAMID: mid_r  <= push(mid_r, hwdata[7:0]);
                    OFF_LBAHI:  hi_r   <= push(hi_r, hwdata[7:0]);
                    OFF_DRVHD:  dh_r   <= hwdata[7:0];
                    default:    ;
                endcase
            end
        end
    end

    // status and host interrupt; a completion beats the clear
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r    <= '0;
            intrq_r <= 1'b0;
        end else begin
            st_r.busy <= state_nxt != S_IDLE;
            st_r.data_request_flag  <= state_nxt == S_PAY; // verify never asks for data
            if (cmd_go) begin
                st_r.abrt <= fin_abrt;
                st_r.unc  <= 1'b0;
            end else if (fin) begin
                st_r.abrt <= fin_abrt;
                st_r.unc  <= fin_unc;
            end
            if (fin) begin
                intrq_r <= 1'b1;
            end else if (stat_rd || cmd_go) begin
                intrq_r <= 1'b0;
            end
        end
    end

    // security state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frozen_r   <= 1'b0;
            prepare_r  <= 1'b0;
            locked_r   <= 1'b0;
            sup_r      <= SUP_RESET;
            erase_op_r <= 1'b0;
            erase_r    <= 1'b0;
            wear_r     <= 1'b0;
        end else begin
            erase_r <= 1'b0;
            wear_r  <= 1'b0;
            if (cmd_go) begin
                // only a completed prepare arms the next erase
                prepare_r  <= opc == CMD_ERPREP;
                erase_op_r <= opc == CMD_ERUNIT;
                if (opc == CMD_FREEZE) begin
                    if (sup_r) begin
                        frozen_r <= 1'b1; // no command clears it
                    end else begin
                        wear_r <= 1'b1;
                    end
                end
            end
            if (wr_r && addr_r == OFF_SECCFG && state_r == S_IDLE) begin
                sup_r <= hwdata[SC_SUP_BIT];
            end
            if (wr_r && addr_r == OFF_PWLOAD && state_r == S_IDLE && !hwdata[PWL_MASTER]) begin
                locked_r <= 1'b1;
            end else if (state_r == S_PAY && pw_done && pw_match) begin
                locked_r <= 1'b0;
                erase_r  <= erase_op_r;
            end
        end
    end

    assign clr_user = state_r == S_PAY && pw_done && pw_match;

    vsch_pw_store u_pw (
        .clk       (clk),
        .rstn      (rstn),
        .ld_en     (wr_r && addr_r == OFF_PWLOAD && state_r == S_IDLE),
        .ld_master (hwdata[PWL_MASTER]),
        .ld_idx    (hwdata[PWL_IDX_LO +: 4]),
        .ld_word   (hwdata[15:0]),
        .clr_user  (clr_user),
        .start     (pay_start),
        .pay_en    (wr_r && addr_r == OFF_DATA && state_r == S_PAY),
        .pay_word  (hwdata[15:0]),
        .done      (pw_done),
        .match     (pw_match),
        .user_set  (user_set)
    );

endmodule

//--- bench/vsch_media_model.sv
/*
 * Media checker model: answers each check request with one done pulse.
 * Assumes the bench sets latency and an optional failing block address.
 */
module vsch_media_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        chk_req,
    input  wire logic [47:0] chk_lba,
    input  wire logic [3:0]  lat,
    input  wire logic [47:0] bad_lba,
    input  wire logic        bad_en,
    output logic             chk_done,
    output logic             chk_err
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       pend_r;
    logic [3:0] cnt_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_r   <= 1'b0;
            cnt_r    <= 4'h0;
            chk_done <= 1'b0;
            chk_err  <= 1'b0;
        end else begin
            chk_done <= 1'b0;
            // error line toggles outside done so it never looks valid by accident
            chk_err  <= ~chk_err;
            if (chk_req) begin
                pend_r <= 1'b1;
                cnt_r  <= lat;
            end else if (pend_r && cnt_r == 4'h0) begin
                pend_r   <= 1'b0;
                chk_done <= 1'b1;
                chk_err  <= bad_en && chk_lba == bad_lba;
            end else if (pend_r) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule

//--- bench/vsch_assertions.sv
/*
 * Checker on the media link and event outputs of the command handler.
 * Assumes binding to vsch_top, one clock, reset asynchronous active low.
 */
module vsch_assertions (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        chk_req,
    input wire logic [47:0] chk_lba,
    input wire logic        chk_done,
    input wire logic        chk_err,
    input wire logic        intrq,
    input wire logic        erase_unit,
    input wire logic        wear_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_req_one_cycle: assert property (chk_req |=> !chk_req)
        else $error("check request longer than one cycle");
    a_req_lba_held: assert property (chk_req |=> $stable(chk_lba))
        else $error("check address moved while outstanding");
    a_busy_no_irq: assert property (chk_req |-> !intrq)
        else $error("interrupt raised while verify still checking");
    a_good_goes_on: assert property (chk_done && !chk_err |-> ##[1:3] (chk_req || intrq))
        else $error("verify stalled after a good sector");
    a_err_stops_here: assert property (chk_done && chk_err |=> (!chk_req && $stable(chk_lba)) [*4])
        else $error("verify went on after a failing sector");
    a_err_raises_irq: assert property (chk_done && chk_err |-> ##[1:3] intrq)
        else $error("no interrupt after failing sector");
    a_erase_completes: assert property (erase_unit |-> ##[0:4] intrq)
        else $error("erase pulse without completion");
    a_wear_one_pulse: assert property (wear_level |=> !wear_level)
        else $error("wear level pulse longer than one cycle");
endmodule

bind vsch_top vsch_assertions u_vsch_chk (
    .clk(clk), .rstn(rstn), .chk_req(chk_req), .chk_lba(chk_lba), .chk_done(chk_done),
    .chk_err(chk_err), .intrq(intrq), .erase_unit(erase_unit), .wear_level(wear_level)
);

//--- bench/vsch_tb.sv
/*
 * Self-checking bench: AHB-Lite register master, verify and security sequences.
 * Assumes vsch_top, the media checker model and the bound checker.
 */
module vsch_tb
    import vsch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rv;
    logic        hreadyout, hresp, chk_req, chk_done, chk_err, intrq, erase_unit, wear_level;
    logic [47:0] chk_lba;
    logic [47:0] bad_lba = 48'h0;
    logic [3:0]  lat = 4'h8;
    logic        bad_en = 1'b1;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          erases = 0;
    int          wears = 0;
    always #25 clk = ~clk;

    vsch_top dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .chk_req(chk_req), .chk_lba(chk_lba),
        .chk_done(chk_done), .chk_err(chk_err), .intrq(intrq), .erase_unit(erase_unit),
        .wear_level(wear_level));
    vsch_media_model media (.clk(clk), .rstn(rstn), .chk_req(chk_req), .chk_lba(chk_lba),
        .lat(lat), .bad_lba(bad_lba), .bad_en(bad_en), .chk_done(chk_done), .chk_err(chk_err));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        erases += erase_unit;
        wears += wear_level;
        if (cycles == 60000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rv = hrdata;
        cmp("response", 32'h0, {31'h0, hresp});
    endtask

    // idle cycle first: a read right after a write sees the old value
    task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
        @(posedge clk);
        xfer(a, 1'b0, 32'h0);
        cmp(nm, e, rv);
    endtask

    task automatic rdaddr(input logic [7:0] lo, input logic [7:0] mi, input logic [7:0] hi);
        rd(OFF_LBALO, "addr low", {24'h0, lo});
        rd(OFF_LBAMID, "addr mid", {24'h0, mi});
        rd(OFF_LBAHI, "addr high", {24'h0, hi});
    endtask

    task automatic tf(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] mi,
                      input logic [7:0] hi);
        xfer(OFF_SCNT, 1'b1, {24'h0, c});
        xfer(OFF_LBALO, 1'b1, {24'h0, lo});
        xfer(OFF_LBAMID, 1'b1, {24'h0, mi});
        xfer(OFF_LBAHI, 1'b1, {24'h0, hi});
    endtask

    task automatic ld(input logic m, input logic [15:0] base);
        for (int i = 0; i < 16; i++) xfer(OFF_PWLOAD, 1'b1, {11'h0, m, 4'(i), base + 16'(i + 1)});
    endtask

    task automatic fin(input logic [7:0] st);
        int n;
        for (n = 0; n < 3000 && intrq !== 1'b1; n++) @(posedge clk);
        cmp("interrupt", 32'h1, {31'h0, intrq});
        rd(OFF_CMD, "status", {24'h0, st});
    endtask

    // payload sent only when pay is set; ignored after an instant abort
    task automatic run(input logic [7:0] op, input logic pay, input logic [15:0] id,
                       input logic [15:0] base, input logic [7:0] st);
        xfer(OFF_CMD, 1'b1, {24'h0, op});
        for (int n = 0; pay && n < 256; n++)
            xfer(OFF_DATA, 1'b1, {16'h0, (n == 0) ? id : ((n < 17) ? base + 16'(n) : 16'h0)});
        fin(st);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(OFF_DRVHD, "drive head", 32'hA0);
        rd(OFF_SECCFG, "security", 32'h10);
        rd(8'h3C, "unmapped", 32'h0);
        for (int i = 0; i < 16; i += 5) run({4'h1, 4'(i)}, 1'b0, 16'h0, 16'h0, 8'h40);
        bad_lba <= 48'h3010206;
        tf(8'h03, 8'h05, 8'h02, 8'h01);
        xfer(OFF_DRVHD, 1'b1, 32'hE3);
        xfer(OFF_CMD, 1'b1, {24'h0, CMD_VFY_A});
        rd(OFF_CMD, "busy status", 32'h80);
        fin(8'h41);
        rd(OFF_FEAT, "error", 32'h40);
        rdaddr(8'h06, 8'h02, 8'h01);
        rd(OFF_DRVHD, "drive head", 32'hE3);
        rd(OFF_SCNT, "count", 32'h02);
        lat <= 4'h0;
        tf(8'h02, 8'hF0, 8'h00, 8'h00);
        run(CMD_VFY_B, 1'b0, 16'h0, 16'h0, 8'h40);
        bad_lba <= 48'h665544112235;
        tf(8'h00, 8'h44, 8'h55, 8'h66);
        tf(8'h03, 8'h33, 8'h22, 8'h11);
        run(CMD_VFY_EXT, 1'b0, 16'h0, 16'h0, 8'h41);
        rdaddr(8'h35, 8'h22, 8'h11);
        rd(OFF_SCNT, "count", 32'h01);
        xfer(OFF_DEVCTL, 1'b1, 32'h80);
        rdaddr(8'h44, 8'h55, 8'h66);
        xfer(OFF_DEVCTL, 1'b1, 32'h00);
        tf(8'h00, 8'h44, 8'h55, 8'h66);
        tf(8'h02, 8'h33, 8'h22, 8'h11);
        run(CMD_VFY_EXT, 1'b0, 16'h0, 16'h0, 8'h40);
        rdaddr(8'h34, 8'h22, 8'h11);
        ld(1'b0, 16'hA000);
        ld(1'b1, 16'hB000);
        rd(OFF_SECCFG, "security", 32'h19);
        run(CMD_DISPW, 1'b1, 16'h0, 16'hA000, 8'h40);
        rd(OFF_SECCFG, "security", 32'h10);
        ld(1'b0, 16'hA000);
        run(CMD_DISPW, 1'b1, 16'h1, 16'hB000, 8'h40);
        rd(OFF_SECCFG, "security", 32'h10);
        ld(1'b0, 16'hA000);
        run(CMD_ERUNIT, 1'b1, 16'h0, 16'hA000, 8'h41);
        run(CMD_ERPREP, 1'b0, 16'h0, 16'h0, 8'h40);
        rd(OFF_SECCFG, "security", 32'h1B);
        run(8'h20, 1'b0, 16'h0, 16'h0, 8'h41);
        run(CMD_ERUNIT, 1'b1, 16'h0, 16'hA000, 8'h41);
        run(CMD_ERPREP, 1'b0, 16'h0, 16'h0, 8'h40);
        run(CMD_ERUNIT, 1'b1, 16'h0, 16'hC000, 8'h41);
        rd(OFF_FEAT, "error", 32'h04);
        run(CMD_ERPREP, 1'b0, 16'h0, 16'h0, 8'h40);
        run(CMD_ERUNIT, 1'b1, 16'h0, 16'hA000, 8'h40);
        cmp("erase pulses", 32'h1, erases);
        ld(1'b0, 16'hA000);
        run(CMD_FREEZE, 1'b0, 16'h0, 16'h0, 8'h40);
        run(CMD_FREEZE, 1'b0, 16'h0, 16'h0, 8'h40);
        rd(OFF_SECCFG, "security", 32'h1D);
        run(CMD_DISPW, 1'b1, 16'h0, 16'hA000, 8'h41);
        run(CMD_ERPREP, 1'b0, 16'h0, 16'h0, 8'h40);
        run(CMD_ERUNIT, 1'b1, 16'h0, 16'hA000, 8'h41);
        cmp("erase pulses", 32'h1, erases);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        rd(OFF_SECCFG, "security", 32'h10);
        xfer(OFF_SECCFG, 1'b1, 32'h00);
        run(CMD_FREEZE, 1'b0, 16'h0, 16'h0, 8'h40);
        cmp("wear pulses", 32'h1, wears);
        rd(OFF_SECCFG, "security", 32'h00);
        conclude();
    end
endmodule
